// >>> hw/sdd_pkg.sv
// Purpose: constants for the segment descriptor decoder
// Assumes: descriptor words arrive as lower and upper 32-bit words
// Notes: offsets are byte addresses on the apb register port
package sdd_pkg;
   localparam int SDD_BASE_HI_MSB = 31;
   localparam int SDD_BASE_HI_LSB = 24;
   localparam int SDD_GRAN_BIT = 23;
   localparam int SDD_SIZE_BIT = 22;
   localparam int SDD_SPARE_BIT = 20;
   localparam int SDD_LIM_HI_MSB = 19;
   localparam int SDD_LIM_HI_LSB = 16;
   localparam int SDD_PRES_BIT = 15;
   localparam int SDD_PRIV_MSB = 14;
   localparam int SDD_PRIV_LSB = 13;
   localparam int SDD_CLASS_BIT = 12;
   localparam int SDD_KIND_MSB = 11;
   localparam int SDD_KIND_LSB = 8;
   localparam int SDD_BASE_MID_MSB = 7;
   localparam int SDD_BASE_MID_LSB = 0;
   localparam int SDD_PAGE_SHIFT = 12;
   localparam int SDD_DESC_BYTES = 8;
   localparam logic [11:0] SDD_OFS_LO = 12'h000;
   localparam logic [11:0] SDD_OFS_HI = 12'h004;
   localparam logic [11:0] SDD_OFS_BASE = 12'h008;
   localparam logic [11:0] SDD_OFS_LIMIT = 12'h00C;
   localparam logic [11:0] SDD_OFS_ATTR = 12'h010;
   localparam logic [11:0] SDD_OFS_IRQ_STAT = 12'h014;
   localparam logic [11:0] SDD_OFS_IRQ_MASK = 12'h018;
   localparam logic [11:0] SDD_OFS_CTRL = 12'h01C;
   localparam logic [31:0] SDD_WORD_RST = 32'h0000_0000;
   localparam logic [1:0] SDD_IRQ_RST = 2'h0;
endpackage : sdd_pkg

// >>> hw/sdd_decoder.sv
// Purpose: segment descriptor decoder with apb register access
// Assumes: core presents both descriptor words with desc_valid
// Notes: decode is combinational on the core port; apb mirrors it
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
// Overview of operation
// - base from upper 31:24, 7:0, lower 31:16
// - extent is upper 19:16 over lower 15:0
// - granularity bit 23 selects 4 KB or byte units
// - code segment: size bit picks 32/16-bit operands
// - stack segment: size bit picks wide/narrow pointer
// - spare bit 20 never affects core decoding; ATTR bit 13 shows it
// - not resident on load raises not-present fault
// - base and extent ignored while not resident
// - privilege ring from upper bits 14:13
// - class bit 12: application versus system
// - kind bits 11:8; 11 executable, 8 accessed
// - kind bit 10 conforming or expand-down
// - kind bit 9 readable or writable
// - descriptor is eight bytes, lower word first
// - table entry zero never valid
module sdd_decoder (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [31:0] desc_lo,
   input wire logic [31:0] desc_hi,
   input wire logic desc_valid,
   input wire logic desc_load,
   input wire logic desc_null,
   output logic [31:0] seg_base,
   output logic [31:0] seg_limit,
   output logic seg_present,
   output logic [1:0] privilege_ring,
   output logic seg_app,
   output logic [3:0] seg_kind,
   output logic seg_exec,
   output logic seg_accessed,
   output logic seg_conforming,
   output logic seg_expand_down,
   output logic seg_readable,
   output logic seg_writable,
   output logic op_wide,
   output logic wide_stack_pointer,
   output logic narrow_stack_pointer,
   output logic seg_valid,
   output logic fault_not_present,
   output logic fault_null,
   output logic irq,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import sdd_pkg::*;

   function automatic logic [31:0] sdd_base(input logic [31:0] lo,
                                            input logic [31:0] hi);
      sdd_base = {hi[SDD_BASE_HI_MSB:SDD_BASE_HI_LSB],
                  hi[SDD_BASE_MID_MSB:SDD_BASE_MID_LSB], lo[31:16]};
   endfunction : sdd_base

   function automatic logic [31:0] sdd_limit(input logic [31:0] lo,
                                             input logic [31:0] hi);
      logic [19:0] ext;
      ext = {hi[SDD_LIM_HI_MSB:SDD_LIM_HI_LSB], lo[15:0]};
      if (hi[SDD_GRAN_BIT]) begin
         sdd_limit = {ext, {SDD_PAGE_SHIFT{1'b1}}};
      end else begin
         sdd_limit = {12'h000, ext};
      end
   endfunction : sdd_limit

   logic [31:0] sw_lo_q;
   logic [31:0] sw_hi_q;
   logic sw_load;
   logic [1:0] irq_stat_q;
   logic [1:0] irq_mask_q;
   logic [31:0] dbase;
   logic [31:0] dlimit;
   logic [31:0] attr;
   logic [31:0] rdata_d;
   logic apb_wr;
   logic apb_rd;
   logic addr_ok;
   logic pres;
   logic app;
   logic [3:0] kind;

   // decode fully combinational so the core sees it the same cycle
   assign pres = desc_hi[SDD_PRES_BIT];
   assign app = desc_hi[SDD_CLASS_BIT];
   assign kind = desc_hi[SDD_KIND_MSB:SDD_KIND_LSB];
   // base/limit forced to zero when absent; software owns those bits
   assign seg_base = pres ? sdd_base(desc_lo, desc_hi) : '0;
   assign seg_limit = pres ? sdd_limit(desc_lo, desc_hi) : '0;
   assign seg_present = pres;
   assign privilege_ring = desc_hi[SDD_PRIV_MSB:SDD_PRIV_LSB];
   assign seg_app = app;
   assign seg_kind = kind;
   assign seg_exec = kind[3];
   assign seg_accessed = kind[0];
   assign seg_conforming = app & kind[2];
   assign seg_expand_down = ~app & kind[2];
   assign seg_readable = app & kind[1];
   assign seg_writable = ~app & kind[1];
   // spare bit deliberately unread in every term above
   assign op_wide = kind[3] & desc_hi[SDD_SIZE_BIT];
   assign wide_stack_pointer = ~kind[3] & desc_hi[SDD_SIZE_BIT];
   assign narrow_stack_pointer = ~kind[3] & ~desc_hi[SDD_SIZE_BIT];
   assign seg_valid = desc_valid & ~desc_null & pres;
   assign fault_null = desc_valid & desc_load & desc_null;
   assign fault_not_present = desc_valid & desc_load & ~desc_null
                              & ~pres;

   // software test path: decode the two words written over apb
   assign dbase = sdd_base(sw_lo_q, sw_hi_q);
   assign dlimit = sdd_limit(sw_lo_q, sw_hi_q);
   assign attr = {16'h0000, sw_hi_q[SDD_GRAN_BIT], sw_hi_q[SDD_SIZE_BIT],
                  sw_hi_q[SDD_SPARE_BIT], sw_hi_q[SDD_PRES_BIT],
                  sw_hi_q[SDD_PRIV_MSB:SDD_PRIV_LSB],
                  sw_hi_q[SDD_CLASS_BIT], 5'h00,
                  sw_hi_q[SDD_KIND_MSB:SDD_KIND_LSB]};

   assign apb_wr = psel & penable & pwrite;
   assign apb_rd = psel & penable & ~pwrite;
   assign pready = 1'b1;
   always_comb begin
      addr_ok = 1'b1;
      rdata_d = SDD_WORD_RST;
      if (paddr == SDD_OFS_LO) begin
         rdata_d = sw_lo_q;
      end else if (paddr == SDD_OFS_HI) begin
         rdata_d = sw_hi_q;
      end else if (paddr == SDD_OFS_BASE) begin
         rdata_d = sw_hi_q[SDD_PRES_BIT] ? dbase : '0;
      end else if (paddr == SDD_OFS_LIMIT) begin
         rdata_d = sw_hi_q[SDD_PRES_BIT] ? dlimit : '0;
      end else if (paddr == SDD_OFS_ATTR) begin
         rdata_d = attr;
      end else if (paddr == SDD_OFS_IRQ_STAT) begin
         rdata_d = {30'h0000_0000, irq_stat_q};
      end else if (paddr == SDD_OFS_IRQ_MASK) begin
         rdata_d = {30'h0000_0000, irq_mask_q};
      end else if (paddr == SDD_OFS_CTRL) begin
         rdata_d = SDD_WORD_RST;
      end else begin
         addr_ok = 1'b0;
      end
   end
   assign pslverr = (apb_wr | apb_rd) & ~addr_ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= SDD_WORD_RST;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= rdata_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_lo_q <= SDD_WORD_RST;
         sw_hi_q <= SDD_WORD_RST;
      end else if (apb_wr && paddr == SDD_OFS_LO) begin
         sw_lo_q <= pwdata;
      end else if (apb_wr && paddr == SDD_OFS_HI) begin
         sw_hi_q <= pwdata;
      end
   end

   assign sw_load = apb_wr && paddr == SDD_OFS_CTRL && pwdata[0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_q <= SDD_IRQ_RST;
      end else if (apb_wr && paddr == SDD_OFS_IRQ_MASK) begin
         irq_mask_q <= pwdata[1:0];
      end
   end

   // set wins over write-one-to-clear so no fault is lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_q <= SDD_IRQ_RST;
      end else begin
         irq_stat_q <= (irq_stat_q &
                        ~((apb_wr && paddr == SDD_OFS_IRQ_STAT) ?
                          pwdata[1:0] : 2'h0))
                       | {fault_null, fault_not_present
                          | (sw_load & ~sw_hi_q[SDD_PRES_BIT])};
      end
   end
   assign irq = |(irq_stat_q & irq_mask_q);

   property p_np_sets;
      @(posedge pclk) disable iff (!presetn)
         fault_not_present |=> irq_stat_q[0];
   endproperty : p_np_sets
   a_np_sets: assert property (p_np_sets)
      else $error("not-present fault did not set status");

   property p_np_cause;
      @(posedge pclk) disable iff (!presetn)
         fault_not_present |-> desc_load && !desc_hi[SDD_PRES_BIT];
   endproperty : p_np_cause
   a_np_cause: assert property (p_np_cause)
      else $error("not-present fault without cause");

   property p_sw_np;
      @(posedge pclk) disable iff (!presetn)
         sw_load && !sw_hi_q[SDD_PRES_BIT] |=> irq_stat_q[0];
   endproperty : p_sw_np
   a_sw_np: assert property (p_sw_np)
      else $error("software load of absent segment not flagged");

   property p_base;
      @(posedge pclk) disable iff (!presetn)
         seg_present |-> seg_base[15:0] == desc_lo[31:16]
         && seg_base[23:16] == desc_hi[7:0]
         && seg_base[31:24] == desc_hi[31:24];
   endproperty : p_base
   a_base: assert property (p_base)
      else $error("base assembled wrong");

   property p_lim;
      @(posedge pclk) disable iff (!presetn)
         seg_present && desc_hi[SDD_GRAN_BIT] |-> seg_limit[11:0] == 12'hFFF
         && seg_limit[31:12] == {desc_hi[19:16], desc_lo[15:0]};
   endproperty : p_lim
   a_lim: assert property (p_lim)
      else $error("page limit wrong");

   property p_blim;
      @(posedge pclk) disable iff (!presetn)
         seg_present && !desc_hi[SDD_GRAN_BIT] |->
         seg_limit == {12'h000, desc_hi[19:16], desc_lo[15:0]};
   endproperty : p_blim
   a_blim: assert property (p_blim)
      else $error("byte limit wrong");

   property p_absent;
      @(posedge pclk) disable iff (!presetn)
         !seg_present |-> seg_base == 0 && seg_limit == 0;
   endproperty : p_absent
   a_absent: assert property (p_absent)
      else $error("absent segment exposes base or limit");

   property p_null;
      @(posedge pclk) disable iff (!presetn)
         desc_null |-> !seg_valid;
   endproperty : p_null
   a_null: assert property (p_null)
      else $error("null entry marked valid");

   property p_null_sets;
      @(posedge pclk) disable iff (!presetn)
         fault_null |=> irq_stat_q[1];
   endproperty : p_null_sets
   a_null_sets: assert property (p_null_sets)
      else $error("null load did not set status");

   property p_null_cause;
      @(posedge pclk) disable iff (!presetn)
         fault_null |-> desc_load && desc_null;
   endproperty : p_null_cause
   a_null_cause: assert property (p_null_cause)
      else $error("null fault without cause");

   property p_fault_excl;
      @(posedge pclk) disable iff (!presetn)
         !(fault_null && fault_not_present);
   endproperty : p_fault_excl
   a_fault_excl: assert property (p_fault_excl)
      else $error("both faults raised together");

   property p_valid;
      @(posedge pclk) disable iff (!presetn)
         seg_valid == (desc_valid && !desc_null && seg_present);
   endproperty : p_valid
   a_valid: assert property (p_valid)
      else $error("segment valid flag wrong");

   property p_ring;
      @(posedge pclk) disable iff (!presetn)
         privilege_ring == desc_hi[14:13];
   endproperty : p_ring
   a_ring: assert property (p_ring)
      else $error("privilege ring wrong");

   property p_class;
      @(posedge pclk) disable iff (!presetn)
         seg_app == desc_hi[SDD_CLASS_BIT]
         && seg_kind == desc_hi[SDD_KIND_MSB:SDD_KIND_LSB];
   endproperty : p_class
   a_class: assert property (p_class)
      else $error("class or kind wrong");

   property p_exec_acc;
      @(posedge pclk) disable iff (!presetn)
         seg_exec == seg_kind[3] && seg_accessed == seg_kind[0];
   endproperty : p_exec_acc
   a_exec_acc: assert property (p_exec_acc)
      else $error("executable or accessed flag wrong");

   property p_perm;
      @(posedge pclk) disable iff (!presetn)
         !(seg_conforming && seg_expand_down)
         && !(seg_readable && seg_writable);
   endproperty : p_perm
   a_perm: assert property (p_perm)
      else $error("permission reading crossed");

   property p_app_bits;
      @(posedge pclk) disable iff (!presetn)
         seg_app |-> seg_conforming == seg_kind[2] && !seg_expand_down
         && seg_readable == seg_kind[1] && !seg_writable;
   endproperty : p_app_bits
   a_app_bits: assert property (p_app_bits)
      else $error("application kind bits read wrong");

   property p_sys_bits;
      @(posedge pclk) disable iff (!presetn)
         !seg_app |-> seg_expand_down == seg_kind[2] && !seg_conforming
         && seg_writable == seg_kind[1] && !seg_readable;
   endproperty : p_sys_bits
   a_sys_bits: assert property (p_sys_bits)
      else $error("system kind bits read wrong");

   property p_code_size;
      @(posedge pclk) disable iff (!presetn)
         seg_exec |-> op_wide == desc_hi[SDD_SIZE_BIT]
         && !wide_stack_pointer && !narrow_stack_pointer;
   endproperty : p_code_size
   a_code_size: assert property (p_code_size)
      else $error("code operand width wrong");

   property p_stack;
      @(posedge pclk) disable iff (!presetn)
         !seg_exec |-> wide_stack_pointer == desc_hi[SDD_SIZE_BIT]
         && narrow_stack_pointer == !desc_hi[SDD_SIZE_BIT]
         && !op_wide;
   endproperty : p_stack
   a_stack: assert property (p_stack)
      else $error("stack width wrong");

   c_np: cover property (@(posedge pclk) fault_not_present);
   c_null: cover property (@(posedge pclk) fault_null);
   c_page: cover property (@(posedge pclk) seg_valid && seg_limit[0]
      && desc_hi[SDD_GRAN_BIT]);
   c_irq: cover property (@(posedge pclk) irq);
endmodule : sdd_decoder

// >>> verification/sdd_desc_mem.sv
// Purpose: descriptor table memory on the far side of the decoder
// Assumes: eight-byte entries, lower word at +0, upper at +4
// Notes: slow mode holds valid low three cycles after an index change
`timescale 1ns/1ps
module sdd_desc_mem (
   input wire logic pclk,
   input wire logic wr_en,
   input wire logic slow,
   input wire logic [2:0] idx,
   input wire logic [31:0] wr_lo,
   input wire logic [31:0] wr_hi,
   output logic [31:0] rd_lo,
   output logic [31:0] rd_hi,
   output logic rd_valid,
   output logic rd_null
);
   logic [7:0] mem_q [64];
   logic [2:0] idx_q = 3'h0;
   logic [1:0] wait_q = 2'h0;
   logic [31:0] lo, hi;
   always_ff @(posedge pclk) begin
      idx_q <= idx;
      if (idx != idx_q) wait_q <= slow ? 2'h2 : 2'h0;
      else if (wait_q != 2'h0) wait_q <= wait_q - 2'h1;
      if (wr_en) for (int i = 0; i < 4; i++) begin
         mem_q[{idx, i[2:0]}] <= wr_lo[8*i+:8];
         mem_q[{idx, 3'(i + 4)}] <= wr_hi[8*i+:8];
      end
   end
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         lo[8*i+:8] = mem_q[{idx, i[2:0]}];
         hi[8*i+:8] = mem_q[{idx, 3'(i + 4)}];
      end
   end
   assign rd_valid = wait_q == 2'h0 && (idx == idx_q || !slow);
   // not settled: inverted words, never stale ones
   assign rd_lo = rd_valid ? lo : ~lo;
   assign rd_hi = rd_valid ? hi : ~hi;
   assign rd_null = idx == 3'h0;
endmodule : sdd_desc_mem

// >>> verification/test_segment_descriptor_decoder.sv
// Purpose: self-checking bench for the descriptor decoder
// Assumes: zero-wait apb, combinational core port
// Notes: table entries come from the partner memory model
`timescale 1ns/1ps
module test_segment_descriptor_decoder;
   import sdd_pkg::*;
   logic pclk, presetn, desc_load, wr_en, slow, psel, penable, pwrite, err;
   logic [2:0] idx;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd_w, wr_lo, wr_hi, desc_lo, desc_hi;
   logic [31:0] seg_base, seg_limit, prdata;
   logic [1:0] privilege_ring;
   logic [3:0] seg_kind;
   logic desc_valid, desc_null, seg_present, seg_app, seg_exec, seg_accessed;
   logic seg_conforming, seg_expand_down, seg_readable, seg_writable, op_wide;
   logic wide_stack_pointer, narrow_stack_pointer, seg_valid;
   logic fault_not_present, fault_null, irq, pready, pslverr;
   int bad_count, total_checks;
   logic [31:0] tlo [6] = '{32'h0bad_f00d, 32'h1234_5678, 32'h1234_5678,
      32'hffff_0000, 32'hdead_beef, 32'h1234_5678};
   logic [31:0] thi [6] = '{32'h0000_9200, 32'habc5_decd, 32'hab15_d1cd,
      32'h0f43_8601, 32'h7755_7a12, 32'habd5_decd};
   sdd_decoder u_dut (.pclk, .presetn, .desc_lo, .desc_hi, .desc_valid,
      .desc_load, .desc_null, .seg_base, .seg_limit, .seg_present,
      .privilege_ring, .seg_app, .seg_kind, .seg_exec, .seg_accessed,
      .seg_conforming, .seg_expand_down, .seg_readable, .seg_writable,
      .op_wide, .wide_stack_pointer, .narrow_stack_pointer, .seg_valid,
      .fault_not_present, .fault_null, .irq, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr);
   sdd_desc_mem u_mem (.pclk, .wr_en, .slow, .idx, .wr_lo, .wr_hi,
      .rd_lo(desc_lo), .rd_hi(desc_hi), .rd_valid(desc_valid),
      .rd_null(desc_null));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   // entered just after a rising edge; leaves one idle cycle
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no local limit: only the watchdog ends a stuck access
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd_w = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic chk_irq(input logic exp);
      @(negedge pclk);
      chk({31'h0, irq}, {31'h0, exp});
      @(posedge pclk);
   endtask : chk_irq
   task automatic run(input logic [2:0] i);
      logic [31:0] lo, hi;
      logic p, c, x, d, nul;
      logic [19:0] ext;
      int n;
      lo = tlo[i];
      hi = thi[i];
      p = hi[15];
      c = hi[12];
      x = hi[11];
      d = hi[22];
      nul = i == 3'h0;
      ext = {hi[19:16], lo[15:0]};
      idx <= i;
      slow <= i[0];
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (desc_valid !== 1'b1 && n < 8);
      @(negedge pclk);
      chk(seg_base, p ? {hi[31:24], hi[7:0], lo[31:16]} : 32'h0);
      chk(seg_limit, !p ? 32'h0 : hi[23] ? {ext, 12'hfff} : {12'h0, ext});
      chk({21'h0, seg_present, privilege_ring, seg_app, seg_kind, seg_valid,
         seg_exec, seg_accessed}, {21'h0, p, hi[14:13], c, hi[11:8],
         p & !nul, x, hi[8]});
      chk({25'h0, seg_conforming, seg_expand_down, seg_readable, seg_writable,
         op_wide, wide_stack_pointer, narrow_stack_pointer}, {25'h0,
         c & hi[10], !c & hi[10], c & hi[9], !c & hi[9], x & d, !x & d,
         !x & !d});
      @(posedge pclk);
      desc_load <= 1'b1;
      @(negedge pclk);
      chk({30'h0, fault_not_present, fault_null}, {30'h0, !p & !nul, nul});
      @(posedge pclk);
      desc_load <= 1'b0;
   endtask : run
   initial begin
      #(40ns * 4000);
      bad_count++;
      results();
   end
   initial begin
      {presetn, desc_load, wr_en, slow, psel, penable, pwrite} = 7'h0;
      {idx, paddr, pwdata, wr_lo, wr_hi} = 111'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, SDD_OFS_IRQ_STAT, 32'h0);
      chk(rd_w, 32'h0);
      for (int i = 0; i < 6; i++) begin
         wr_en <= 1'b1;
         idx <= 3'(i);
         wr_lo <= tlo[i];
         wr_hi <= thi[i];
         @(posedge pclk);
      end
      wr_en <= 1'b0;
      for (int i = 0; i < 6; i++) run(3'(i));
      $display("core decode test done");
      apb(1'b0, SDD_OFS_IRQ_STAT, 32'h0);
      chk(rd_w, 32'h3);
      chk_irq(1'b0);
      apb(1'b1, SDD_OFS_IRQ_MASK, 32'h3);
      chk_irq(1'b1);
      apb(1'b1, SDD_OFS_IRQ_STAT, 32'h1);
      apb(1'b0, SDD_OFS_IRQ_STAT, 32'h0);
      chk(rd_w, 32'h2);
      apb(1'b1, SDD_OFS_IRQ_STAT, 32'h2);
      chk_irq(1'b0);
      $display("interrupt test done");
      apb(1'b1, SDD_OFS_LO, tlo[1]);
      apb(1'b1, SDD_OFS_HI, thi[1]);
      apb(1'b0, SDD_OFS_HI, 32'h0);
      chk(rd_w, thi[1]);
      apb(1'b0, SDD_OFS_BASE, 32'h0);
      chk(rd_w, 32'habcd_1234);
      apb(1'b0, SDD_OFS_LIMIT, 32'h0);
      chk(rd_w, 32'h5567_8fff);
      apb(1'b0, SDD_OFS_ATTR, 32'h0);
      chk(rd_w, 32'h0000_da0e);
      apb(1'b0, 12'h100, 32'h0);
      chk({err, rd_w[30:0]}, 32'h8000_0000);
      apb(1'b1, SDD_OFS_HI, thi[4]);
      apb(1'b1, SDD_OFS_CTRL, 32'h1);
      apb(1'b0, SDD_OFS_BASE, 32'h0);
      chk(rd_w, 32'h0);
      apb(1'b0, SDD_OFS_IRQ_STAT, 32'h0);
      chk(rd_w, 32'h1);
      $display("register test done");
      // mid-run reset must drop irq at once and clear the irq mask and upper word
      chk_irq(1'b1);
      presetn <= 1'b0;
      chk_irq(1'b0);
      presetn <= 1'b1;
      apb(1'b0, SDD_OFS_IRQ_MASK, 32'h0);
      chk(rd_w, 32'h0);
      apb(1'b0, SDD_OFS_HI, 32'h0);
      chk(rd_w, 32'h0);
      $display("reset test done");
      results();
   end
endmodule : test_segment_descriptor_decoder
